// File: hdl/dlrs_defines.vh
// constants for the debug link target-select block
// Behaviour
// - link uses a host-driven clock and one bidirectional data line.
// - every link register is reached only through link transactions.
// - 8-bit target select chooses the register for later data reads and writes.
// - target select 0x00 makes data reads return the part identifier.
// - target select 0x01 makes data reads return the silicon revision.
// - target select 0x02 makes data reads and writes use programming control.
// - target select 0xB4 makes data reads and writes use programming data.
// - part identifier is read-only, a fixed 8-bit code; writes ignored.
// - silicon revision is read-only, 8-bit, zero means first revision.
// - writing 0x02 then 0x01 to programming control enables programming until reset.
// - flash command codes: 0x06 read, 0x07 write, 0x08 page erase, 0x03 erase.
`ifndef DLRS_DEFINES_VH
`define DLRS_DEFINES_VH

// ****************************************
// target select values
// ****************************************
`define DLRS_SEL_PART_ID 8'h00
`define DLRS_SEL_REVISION 8'h01
`define DLRS_SEL_PROG_CTRL 8'h02
`define DLRS_SEL_PROG_DATA 8'hB4
`define DLRS_ADDR_PART_ID 8'hFD
`define DLRS_ADDR_REVISION 8'hFE

// ****************************************
// reset values
// ****************************************
`define DLRS_RST_TSEL 8'h00
`define DLRS_RST_PROG_CTRL 8'h00
`define DLRS_RST_PROG_DATA 8'h00

// ****************************************
// programming unlock and flash commands
// ****************************************
`define DLRS_UNLOCK_FIRST 8'h02
`define DLRS_UNLOCK_SECOND 8'h01
`define DLRS_CMD_BLOCK_READ 8'h06
`define DLRS_CMD_BLOCK_WRITE 8'h07
`define DLRS_CMD_PAGE_ERASE 8'h08
`define DLRS_CMD_DEVICE_ERASE 8'h03
`define DLRS_FCMD_BLOCK_READ 0
`define DLRS_FCMD_BLOCK_WRITE 1
`define DLRS_FCMD_PAGE_ERASE 2
`define DLRS_FCMD_DEVICE_ERASE 3

// ****************************************
// link frame layout
// ****************************************
`define DLRS_INS_DATA_READ 2'b00
`define DLRS_INS_DATA_WRITE 2'b01
`define DLRS_INS_ADDR_READ 2'b10
`define DLRS_INS_ADDR_WRITE 2'b11
`define DLRS_INS_BITS 3'd2
`define DLRS_DATA_LAST 3'd7
`define DLRS_FRAME_TIMEOUT 8'h40

`endif

// File: hdl/dlrs_sync.v
// two-flop synchroniser with a third stage for edge detection
`timescale 1ns/1ps
module dlrs_sync #(
	parameter WIDTH = 2
) (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out,
	output reg [WIDTH-1:0] prev_out
);
	reg [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			meta <= {WIDTH{1'b1}};
			sync_out <= {WIDTH{1'b1}};
			prev_out <= {WIDTH{1'b1}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
			prev_out <= sync_out;
		end
	end
endmodule // dlrs_sync

// File: hdl/dlrs_link_regs.v
// device end of the two-wire debug link with its target-select registers
`timescale 1ns/1ps
`include "dlrs_defines.vh"
module dlrs_link_regs #(
	// arbitrary neutral value, not a real part code
	parameter [7:0] PART_ID = 8'h5A,
	parameter [7:0] REVISION = 8'h00
) (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire link_clock_pin_in,
	input wire link_data_pin_in,
	output reg link_data_pin_out,
	output reg link_data_pin_oe_out,
	output reg [7:0] link_target_select_out,
	output reg prog_mode_out,
	output reg [7:0] prog_data_out,
	output reg prog_data_strobe_out,
	output reg [3:0] flash_cmd_out
);
	// ****************************************
	// frame states
	// ****************************************
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_INS = 4'b0010;
	localparam [3:0] ST_WDAT = 4'b0100;
	localparam [3:0] ST_RDAT = 4'b1000;

	wire [1:0] pin_sync;
	wire [1:0] pin_prev;
	wire ck_rise;
	wire din;
	reg [3:0] state;
	reg [2:0] bit_cnt;
	reg [1:0] ins;
	reg [7:0] shift;
	reg [7:0] prog_ctrl;
	reg unlock_armed;
	reg [7:0] rd_value;
	reg [7:0] wr_byte;
	reg [3:0] cmd_hit;
	reg [7:0] idle_cnt;

	dlrs_sync #(
		.WIDTH(2)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.async_in({link_clock_pin_in, link_data_pin_in}),
		.sync_out(pin_sync),
		.prev_out(pin_prev)
	);

	// data is taken on the link clock rising edge
	assign ck_rise = pin_sync[1] & ~pin_prev[1];
	assign din = pin_sync[0];

	// ****************************************
	// read mux
	// ****************************************
	always @* begin
		rd_value = 8'h00;
		if (ins == `DLRS_INS_ADDR_READ) begin
			rd_value = link_target_select_out;
		end else begin
			case (link_target_select_out)
				`DLRS_SEL_PART_ID: begin
					rd_value = PART_ID;
				end
				`DLRS_SEL_REVISION: begin
					rd_value = REVISION;
				end
				`DLRS_SEL_PROG_CTRL: begin
					rd_value = prog_ctrl;
				end
				`DLRS_SEL_PROG_DATA: begin
					rd_value = prog_data_out;
				end
				default: begin
					rd_value = 8'h00;
				end
			endcase
		end
	end

	// assembled byte with the last bit still on the wire
	always @* begin
		wr_byte = {din, shift[7:1]};
	end

	always @* begin
		cmd_hit = 4'h0;
		cmd_hit[`DLRS_FCMD_BLOCK_READ] = (wr_byte == `DLRS_CMD_BLOCK_READ);
		cmd_hit[`DLRS_FCMD_BLOCK_WRITE] = (wr_byte == `DLRS_CMD_BLOCK_WRITE);
		cmd_hit[`DLRS_FCMD_PAGE_ERASE] = (wr_byte == `DLRS_CMD_PAGE_ERASE);
		cmd_hit[`DLRS_FCMD_DEVICE_ERASE] = (wr_byte == `DLRS_CMD_DEVICE_ERASE);
	end

	// ****************************************
	// frame engine and registers
	// ****************************************
	// only the link frame below writes or reads these registers
	always @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state <= ST_IDLE;
			bit_cnt <= 3'd0;
			ins <= 2'b00;
			shift <= 8'h00;
			link_target_select_out <= `DLRS_RST_TSEL;
			prog_ctrl <= `DLRS_RST_PROG_CTRL;
			prog_data_out <= `DLRS_RST_PROG_DATA;
			unlock_armed <= 1'b0;
			prog_mode_out <= 1'b0;
			prog_data_strobe_out <= 1'b0;
			flash_cmd_out <= 4'h0;
			link_data_pin_out <= 1'b0;
			link_data_pin_oe_out <= 1'b0;
			idle_cnt <= 8'h00;
		end else begin
			prog_data_strobe_out <= 1'b0;
			flash_cmd_out <= 4'h0;
			// a host that stops mid-frame must not make us misread its next start bit
			if (ck_rise || state == ST_IDLE) begin
				idle_cnt <= 8'h00;
			end else if (idle_cnt != `DLRS_FRAME_TIMEOUT) begin
				idle_cnt <= idle_cnt + 8'h01;
			end
			if (idle_cnt == `DLRS_FRAME_TIMEOUT && state != ST_IDLE) begin
				// stalled frame: drop it and release the data wire
				state <= ST_IDLE;
				bit_cnt <= 3'd0;
				link_data_pin_oe_out <= 1'b0;
				link_data_pin_out <= 1'b0;
			end else if (ck_rise) begin
				case (state)
					ST_IDLE: begin
						// a low data bit on a rising edge is the start bit
						if (!din) begin
							state <= ST_INS;
							bit_cnt <= 3'd0;
						end
					end
					ST_INS: begin
						ins <= {din, ins[1]};
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == `DLRS_INS_BITS - 3'd1) begin
							bit_cnt <= 3'd0;
							if (ins[1] == 1'b0) begin
								// bit 0 of the instruction arrived first
								state <= ST_RDAT;
							end else begin
								state <= ST_WDAT;
							end
							if (din == 1'b0) begin
								state <= ST_RDAT;
							end else begin
								state <= ST_WDAT;
							end
						end
					end
					ST_WDAT: begin
						shift <= wr_byte;
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == `DLRS_DATA_LAST) begin
							state <= ST_IDLE;
							bit_cnt <= 3'd0;
							if (ins == `DLRS_INS_ADDR_WRITE) begin
								link_target_select_out <= wr_byte;
							end else if (link_target_select_out == `DLRS_SEL_PROG_CTRL) begin
								prog_ctrl <= wr_byte;
								unlock_armed <= (wr_byte == `DLRS_UNLOCK_FIRST);
								if (unlock_armed && wr_byte == `DLRS_UNLOCK_SECOND) begin
									prog_mode_out <= 1'b1;
								end
							end else if (link_target_select_out == `DLRS_SEL_PROG_DATA) begin
								prog_data_out <= wr_byte;
								prog_data_strobe_out <= 1'b1;
								// commands only count once programming is on
								if (prog_mode_out) begin
									flash_cmd_out <= cmd_hit;
								end
							end
							// part id and revision writes fall through here
						end
					end
					ST_RDAT: begin
						// host sampled the bit on this edge; present the next
						shift <= {1'b0, shift[7:1]};
						link_data_pin_out <= shift[1];
						bit_cnt <= bit_cnt + 3'd1;
						if (bit_cnt == `DLRS_DATA_LAST) begin
							state <= ST_IDLE;
							bit_cnt <= 3'd0;
							link_data_pin_oe_out <= 1'b0;
							link_data_pin_out <= 1'b0;
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end else if (state == ST_RDAT && !link_data_pin_oe_out) begin
				// first read bit goes out as soon as the instruction is known
				shift <= rd_value;
				link_data_pin_out <= rd_value[0];
				link_data_pin_oe_out <= 1'b1;
			end
		end
	end
endmodule // dlrs_link_regs

// File: verif/dlrs_chk_sva.sv
// assertion checker for the debug link register block
`timescale 1ns/1ps
module dlrs_chk (
	input wire ref_clk_in,
	input wire resetn_in,
	input wire link_data_pin_oe_out,
	input wire [7:0] link_target_select_out,
	input wire prog_mode_out,
	input wire [7:0] prog_data_out,
	input wire prog_data_strobe_out,
	input wire [3:0] flash_cmd_out
);
	// ****************
	// properties
	// ****************
	wire [7:0] pd = prog_data_out;
	wire [3:0] cmd_exp = {pd == 8'h03, pd == 8'h08, pd == 8'h07, pd == 8'h06};
	wire wr_cmd = prog_data_strobe_out && prog_mode_out;
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	property p_rst_sel; $rose(resetn_in) |-> link_target_select_out == 8'h00 && !prog_mode_out;
	endproperty
	a_rst_sel: assert property (p_rst_sel) else $error("select not clear after reset");
	property p_cmd_code; wr_cmd |-> flash_cmd_out == cmd_exp; endproperty
	a_cmd_code: assert property (p_cmd_code) else $error("wrong command pulse");
	property p_no_cmd; !wr_cmd |-> flash_cmd_out == 4'h0; endproperty
	a_no_cmd: assert property (p_no_cmd) else $error("command pulse without write");
	property p_mode_sticky; prog_mode_out |=> prog_mode_out; endproperty
	a_mode_sticky: assert property (p_mode_sticky) else $error("program mode dropped");
	property p_mode_sel; $rose(prog_mode_out) |-> link_target_select_out == 8'h02; endproperty
	a_mode_sel: assert property (p_mode_sel) else $error("mode set off control");
	property p_pdata_chg; $changed(prog_data_out) |-> prog_data_strobe_out; endproperty
	a_pdata_chg: assert property (p_pdata_chg) else $error("data changed unwritten");
	property p_oe_span; $rose(link_data_pin_oe_out) |-> link_data_pin_oe_out [*8]; endproperty
	a_oe_span: assert property (p_oe_span) else $error("read drive too short");
	property p_stb_pulse; prog_data_strobe_out |=> !prog_data_strobe_out; endproperty
	a_stb_pulse: assert property (p_stb_pulse) else $error("strobe longer than one cycle");
	cover property (wr_cmd && flash_cmd_out != 4'h0);
	cover property ($rose(link_data_pin_oe_out));
	cover property ($rose(prog_mode_out));
endmodule // dlrs_chk
bind dlrs_link_regs dlrs_chk dlrs_chk_inst (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
	.link_data_pin_oe_out(link_data_pin_oe_out), .link_target_select_out(link_target_select_out),
	.prog_mode_out(prog_mode_out), .prog_data_out(prog_data_out),
	.prog_data_strobe_out(prog_data_strobe_out), .flash_cmd_out(flash_cmd_out));

// File: verif/dlrs_host.sv
// host model driving the link clock and the shared data wire
`timescale 1ns/1ps
module dlrs_host (
	input wire wire_in,
	output reg clk_out,
	output reg drv_out,
	output reg oe_out
);
	// ****************
	// link bits
	// ****************
	initial begin
		clk_out = 0;
		drv_out = 1;
		oe_out = 0;
	end
	// data set while clock low, sampled at the rise
	task bit_cyc(input logic en, input logic d, output logic s);
		oe_out = en;
		drv_out = d;
		#160;
		clk_out = 1;
		s = wire_in;
		#160;
		clk_out = 0;
	endtask
	task frame(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
		logic s;
		integer k;
		// start bit, then i0 and i1, then a byte lsb first
		bit_cyc(1, 0, s);
		bit_cyc(1, ins[0], s);
		bit_cyc(1, ins[1], s);
		for (k = 0; k < 8; k++) begin
			bit_cyc(ins != 2'b00, wd[k], s);
			rd[k] = s;
		end
		// released wire floats to the pull-up level
		oe_out = 0;
	endtask
	// a frame abandoned after its first instruction bit
	task cut_frame;
		logic s;
		bit_cyc(1, 0, s);
		bit_cyc(1, 1, s);
		oe_out = 0;
	endtask
endmodule // dlrs_host

// File: verif/tb.sv
// self-checking testbench for the debug link register block
`timescale 1ns/1ps
module tb;
	// ****************
	// bench
	// ****************
	logic ref_clk_in = 0;
	logic resetn_in = 0;
	wire h_clk, h_drv, h_oe, oe, dout, mode, stb, link_wire;
	wire [7:0] tsel, pdata;
	wire [3:0] cmd;
	logic [7:0] rd, seen, w, exp_q[$];
	logic [3:0] last_cmd = 4'hF;
	logic [31:0] seed = 32'hb952;
	logic [31:0] r;
	integer error_cnt = 0, n_tests = 0, i;
	event got;
	always #20 ref_clk_in = ~ref_clk_in;
	assign link_wire = oe ? dout : (h_oe ? h_drv : 1'b1);
	dlrs_host dlrs_host_inst (.wire_in(link_wire), .clk_out(h_clk), .drv_out(h_drv),
		.oe_out(h_oe));
	dlrs_link_regs #(.PART_ID(8'hA5), .REVISION(8'h3C)) dlrs_link_regs_inst (
		.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link_clock_pin_in(h_clk),
		.link_data_pin_in(link_wire), .link_data_pin_out(dout), .link_data_pin_oe_out(oe),
		.link_target_select_out(tsel), .prog_mode_out(mode), .prog_data_out(pdata),
		.prog_data_strobe_out(stb), .flash_cmd_out(cmd));
	always @(posedge ref_clk_in) if (stb) last_cmd <= cmd;
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task check(input logic [7:0] v, input logic [7:0] e);
		n_tests++;
		if (v !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	always @(got) check(seen, exp_q.pop_front());
	task obs(input logic [7:0] v, input logic [7:0] e);
		exp_q.push_back(e);
		seen = v;
		->got;
		#1;
	endtask
	task fr(input logic [1:0] ins, input logic [7:0] wd);
		@(negedge ref_clk_in);
		dlrs_host_inst.frame(ins, wd, rd);
		repeat (4) @(negedge ref_clk_in);
	endtask
	task wrap_up;
		$display("errors=%0d tests=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#1000000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		repeat (8) @(negedge ref_clk_in);
		resetn_in = 1;
		repeat (4) @(negedge ref_clk_in);
		obs(tsel, 8'h00);
		fr(2'b00, 0);
		obs(rd, 8'hA5);
		fr(2'b10, 8'h77);
		fr(2'b00, 0);
		obs(rd, 8'hA5);
		fr(2'b11, 8'h01);
		obs(tsel, 8'h01);
		fr(2'b00, 0);
		obs(rd, 8'h3C);
		r = xs();
		w = {3'b110, r[4:0]};
		fr(2'b11, w);
		fr(2'b10, 8'hFF);
		fr(2'b00, 0);
		obs(rd, 8'h00);
		fr(2'b11, 8'hB4);
		r = xs();
		w = r[7:0];
		fr(2'b10, w);
		obs(pdata, w);
		fr(2'b00, 0);
		obs(rd, w);
		fr(2'b10, 8'h06);
		obs({4'h0, last_cmd}, 8'h00);
		fr(2'b11, 8'h02);
		fr(2'b10, 8'h02);
		obs({7'h0, mode}, 8'h00);
		fr(2'b10, 8'h01);
		obs({7'h0, mode}, 8'h01);
		fr(2'b00, 0);
		obs(rd, 8'h01);
		fr(2'b11, 8'hB4);
		for (i = 0; i < 4; i++) begin
			fr(2'b10, i == 3 ? 8'h03 : 8'h06 + i);
			obs({4'h0, last_cmd}, 8'h01 << i);
		end
		// a frame cut after one instruction bit must time out, not eat the next start bit
		@(negedge ref_clk_in);
		dlrs_host_inst.cut_frame;
		repeat (80) @(negedge ref_clk_in);
		fr(2'b00, 0);
		obs(rd, 8'h03);
		resetn_in = 0;
		repeat (2) @(negedge ref_clk_in);
		resetn_in = 1;
		@(negedge ref_clk_in);
		obs({7'h0, mode}, 8'h00);
		obs(tsel, 8'h00);
		wrap_up;
	end
endmodule // tb
